// File: verilog/scp_spi_port.v
// Serial control port slave: 16-bit instruction, counted or streamed
// payload, counted runs stall on byte boundaries, internal config register.
// Assumes the register map answers a read in the cycle its strobe is
// high and that all pins are asynchronous to ref_clk_in.
//
// Summary of operation
// - Select pin chooses SPI or I2C port.
// - Bus address is 11011 plus two straps.
// - Sample on SCLK rise, launch on fall.
// - Bidirectional uses SDIO; unidirectional uses SERIAL_DATA_OUTPUT.
// - Reset gives bidirectional, MSB-first mode.
// - Chip select high tristates SDIO and SERIAL_DATA_OUTPUT.
// - Chip select falling in idle starts a new instruction.
// - Short transfers may stall on byte boundaries.
// - Short aborted frame returns machine to idle.
// - Mid-byte deselect flushes data, resets machine.
// - Streaming runs until chip select rises.
// - Count code 00/01/10 bytes, 11 streams.
// - First 16 rising edges carry instruction.
// - Instruction is direction, count, 13-bit address.
// - Writes go to buffer registers, not active.
// - Stall after full bytes; final byte ends.
// - Writes never skip reserved or unused addresses.
// - Only the 16-bit instruction form exists.
// - Reads shift out N times 8 bits.
// - Readback walks every address in turn.
// - Readback from buffer or active registers.
// - Config register 0x00 lives in port.
// - Config bit 6 selects LSB-first next operation.
// - MSB-first decrements address, LSB-first increments.
`timescale 1ns/1ps
`include "scp_map.vh"

module scp_spi_port #(
  parameter ADDR_W = 13,                        // Register address width
  parameter DATA_W = 8                          // Register data width
) (
  input  wire              ref_clk_in,          // System clock, 40 MHz
  input  wire              rst_n_in,            // Synchronous reset, active low
  input  wire              interface_select_pin_in, // High selects I2C port
  input  wire              addr_strap_upper_in, // Bus address bit 1 strap
  input  wire              addr_strap_lower_in, // Bus address bit 0 strap
  input  wire              sclk_in,             // Serial clock from host
  input  wire              cs_n_in,             // Chip select, active low
  input  wire              sdio_in,             // SDIO pin level
  output wire              sdio_out,            // SDIO drive value
  output wire              sdio_oe_out,         // SDIO drive enable
  output wire              serial_data_output_out,    // SERIAL_DATA_OUTPUT drive value
  output wire              serial_data_output_oe_out, // SERIAL_DATA_OUTPUT drive enable
  output wire [ADDR_W-1:0] reg_addr_out,        // Register map address
  output wire [DATA_W-1:0] reg_wdata_out,       // Buffer write data
  output wire              reg_wr_out,          // Buffer write strobe
  output wire              reg_rd_out,          // Read strobe
  input  wire [DATA_W-1:0] reg_rdata_in,        // Read data, same cycle
  input  wire              readback_active_in,  // Read active not buffer
  output wire              reg_rd_active_out,   // Source for this read
  output wire              cfg_lsb_first_out,   // Config LSB-first bit
  output wire              cfg_unidir_out,      // Config unidirectional bit
  output wire              spi_mode_out,        // SPI port selected
  output wire [6:0]        i2c_addr_out,        // Bus slave address
  output wire              busy_out             // Frame in progress
);

  ////////////////////////////////////////////////////////////////////
  // States, one-hot
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_INSTR = 5'h02;
  localparam [4:0] ST_WDATA = 5'h04;
  localparam [4:0] ST_RDATA = 5'h08;
  localparam [4:0] ST_DONE  = 5'h10;
  localparam [ADDR_W-1:0] ADDR_ONE = {{(ADDR_W-1){1'b0}}, 1'b1};
  ////////////////////////////////////////////////////////////////////
  // Next address in a multibyte run
  function [ADDR_W-1:0] step_addr;
    input [ADDR_W-1:0] addr;
    input              lsb;
    begin
      if (lsb)
        step_addr = addr + ADDR_ONE;
      else
        step_addr = addr - ADDR_ONE;
    end
  endfunction
  // Byte just completed in the shift register
  function [7:0] byte_of;
    input [15:0] sh;
    input        lsb;
    begin
      if (lsb)
        byte_of = sh[15:8];
      else
        byte_of = sh[7:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [5:0] pins_s;
  scp_sync #(
    .WIDTH   (6),
    .RST_VAL (6'h02)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({addr_strap_lower_in, addr_strap_upper_in,
                  interface_select_pin_in, sdio_in, cs_n_in, sclk_in}),
    .sync_out   (pins_s)
  );

  wire sclk_s   = pins_s[0];
  wire cs_n_s   = pins_s[1];
  wire sdio_s   = pins_s[2];
  wire sel_s    = pins_s[3];
  wire upper_s  = pins_s[4];
  wire lower_s  = pins_s[5];
  ////////////////////////////////////////////////////////////////////
  // Registers
  reg [4:0]        state_q;
  reg              sclk_prev_q;
  reg              cs_prev_q;
  reg [3:0]        cnt_q;
  reg [15:0]       sh_q;
  reg [ADDR_W-1:0] addr_q;
  reg [1:0]        left_q;
  reg              stream_q;
  reg              lsb_act_q;
  reg              uni_act_q;
  reg [7:0]        cfg_q;
  reg [7:0]        tx_q;
  reg              ld_pend_q;
  reg              sdio_q;
  reg              sdio_oe_q;
  reg              sdo_q;
  reg              sdo_oe_q;
  reg [ADDR_W-1:0] reg_addr_q;
  reg [DATA_W-1:0] reg_wdata_q;
  reg              reg_wr_q;
  reg              reg_rd_q;
  reg              rd_active_q;
  reg              spi_mode_q;
  reg [6:0]        i2c_addr_q;
  reg              busy_q;
  ////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised pins
  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s & sclk_prev_q;
  wire cs_rise   = cs_n_s & ~cs_prev_q;
  wire cs_fall   = ~cs_n_s & cs_prev_q;
  // Shift register with the next serial bit inserted
  wire [15:0] sh_nxt = lsb_act_q ? {sdio_s, sh_q[15:1]}
                                 : {sh_q[14:0], sdio_s};
  wire [7:0]  rx_byte  = byte_of(sh_nxt, lsb_act_q);
  wire        byte_end = (cnt_q[2:0] == 3'h7);
  wire        mid_byte = (cnt_q[2:0] != 3'h0);
  wire [ADDR_W-1:0] addr_nxt = step_addr(addr_q, lsb_act_q);
  // Instruction fields, same layout in either bit order
  wire              ins_rw   = sh_nxt[`SCP_INSTR_RW_BIT];
  wire [1:0]        ins_cnt  = sh_nxt[`SCP_INSTR_CNT_HI:`SCP_INSTR_CNT_LO];
  wire [ADDR_W-1:0] ins_addr = sh_nxt[ADDR_W-1:0];

  ////////////////////////////////////////////////////////////////////
  // Serial state machine, port mode, shifting and register access
  always @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q     <= ST_IDLE;
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
      cnt_q       <= 4'h0;
      sh_q        <= 16'h0000;
      addr_q      <= {ADDR_W{1'b0}};
      left_q      <= 2'h0;
      stream_q    <= 1'b0;
      lsb_act_q   <= 1'b0;
      uni_act_q   <= 1'b0;
      cfg_q       <= `SCP_CFG_RESET;
      tx_q        <= 8'h00;
      ld_pend_q   <= 1'b0;
      sdio_q      <= 1'b0;
      sdio_oe_q   <= 1'b0;
      sdo_q       <= 1'b0;
      sdo_oe_q    <= 1'b0;
      reg_addr_q  <= {ADDR_W{1'b0}};
      reg_wdata_q <= {DATA_W{1'b0}};
      reg_wr_q    <= 1'b0;
      reg_rd_q    <= 1'b0;
      rd_active_q <= 1'b0;
      busy_q      <= 1'b0;
      spi_mode_q  <= 1'b1;
      i2c_addr_q  <= 7'h00;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_n_s;
      reg_wr_q    <= 1'b0;
      reg_rd_q    <= 1'b0;
      ld_pend_q   <= 1'b0;
      busy_q      <= (state_q != ST_IDLE);
      spi_mode_q  <= ~sel_s;
      i2c_addr_q  <= {`SCP_BUS_ADDR_HI, upper_s, lower_s};
      // Load the byte to send once its read answer is present
      if (ld_pend_q)
        tx_q <= (reg_addr_q == `SCP_CFG_ADDR) ? cfg_q : reg_rdata_in[7:0];

      if (!spi_mode_q)
      begin
        // Other port owns the pins
        state_q   <= ST_IDLE;
        sdio_oe_q <= 1'b0;
        sdo_oe_q  <= 1'b0;
      end
      else if (cs_n_s)
      begin
        // Deselected: pins released
        sdio_oe_q <= 1'b0;
        sdo_oe_q  <= 1'b0;
        if (cs_rise)
        begin
          case (state_q)
            ST_INSTR, ST_WDATA, ST_RDATA:
            begin
              if (mid_byte)
              begin
                // Partial byte discarded, machine reset
                state_q <= ST_IDLE;
                cnt_q   <= 4'h0;
                sh_q    <= 16'h0000;
              end
              else if (stream_q && (state_q != ST_INSTR))
                state_q <= ST_IDLE;
              // Otherwise stalled on a byte boundary, state held
            end
            ST_DONE:
              state_q <= ST_IDLE;
            default:
              state_q <= state_q;
          endcase
        end
      end
      else
      begin
        // Selected: drive the output pin chosen by mode
        sdo_oe_q  <= uni_act_q;
        sdio_oe_q <= ~uni_act_q && (state_q == ST_RDATA);

        if (cs_fall && (state_q == ST_IDLE))
        begin
          // New instruction; mode bits take effect here
          state_q   <= ST_INSTR;
          cnt_q     <= 4'h0;
          sh_q      <= 16'h0000;
          stream_q  <= 1'b0;
          lsb_act_q <= cfg_q[`SCP_CFG_LSB_BIT];
          uni_act_q <= cfg_q[`SCP_CFG_UNI_BIT];
        end
        else if (sclk_rise)
        begin
          cnt_q <= cnt_q + 4'h1;
          sh_q  <= sh_nxt;
          case (state_q)
            ST_INSTR:
            begin
              // Sixteen edges make the only instruction form
              if (cnt_q == 4'hF)
              begin
                addr_q   <= ins_addr;
                stream_q <= (ins_cnt == `SCP_CNT_STREAM);
                left_q   <= ins_cnt;
                if (ins_rw)
                begin
                  state_q     <= ST_RDATA;
                  reg_addr_q  <= ins_addr;
                  reg_rd_q    <= (ins_addr != `SCP_CFG_ADDR);
                  rd_active_q <= readback_active_in;
                  ld_pend_q   <= 1'b1;
                end
                else
                  state_q <= ST_WDATA;
              end
            end
            ST_WDATA:
            begin
              if (byte_end)
              begin
                if (addr_q == `SCP_CFG_ADDR)
                begin
                  // Port config, kept out of the register map
                  cfg_q <= rx_byte & ((8'h01 << `SCP_CFG_LSB_BIT) |
                                      (8'h01 << `SCP_CFG_UNI_BIT));
                end
                else
                begin
                  reg_addr_q  <= addr_q;
                  reg_wdata_q <= rx_byte[DATA_W-1:0];
                  reg_wr_q    <= 1'b1;
                end
                addr_q <= addr_nxt;
                if (!stream_q)
                begin
                  if (left_q == 2'h0)
                    state_q <= ST_DONE;
                  else
                    left_q <= left_q - 2'h1;
                end
              end
            end
            ST_RDATA:
            begin
              if (byte_end)
              begin
                if (!stream_q && (left_q == 2'h0))
                  state_q <= ST_DONE;
                else
                begin
                  if (!stream_q)
                    left_q <= left_q - 2'h1;
                  // Fetch next address, none skipped
                  addr_q      <= addr_nxt;
                  reg_addr_q  <= addr_nxt;
                  reg_rd_q    <= (addr_nxt != `SCP_CFG_ADDR);
                  rd_active_q <= readback_active_in;
                  ld_pend_q   <= 1'b1;
                end
              end
            end
            default:
              state_q <= state_q;
          endcase
        end
        else if (sclk_fall && (state_q == ST_RDATA))
        begin
          // Launch next read bit on the falling edge, order per mode
          sdio_q <= lsb_act_q ? tx_q[0] : tx_q[7];
          sdo_q  <= lsb_act_q ? tx_q[0] : tx_q[7];
          tx_q   <= lsb_act_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign sdio_out                  = sdio_q;
  assign sdio_oe_out               = sdio_oe_q;
  assign serial_data_output_out    = sdo_q;
  assign serial_data_output_oe_out = sdo_oe_q;
  assign reg_addr_out              = reg_addr_q;
  assign reg_wdata_out             = reg_wdata_q;
  assign reg_wr_out                = reg_wr_q;
  assign reg_rd_out                = reg_rd_q;
  assign reg_rd_active_out         = rd_active_q;
  assign cfg_lsb_first_out         = cfg_q[`SCP_CFG_LSB_BIT];
  assign cfg_unidir_out            = cfg_q[`SCP_CFG_UNI_BIT];
  assign spi_mode_out              = spi_mode_q;
  assign i2c_addr_out              = i2c_addr_q;
  assign busy_out                  = busy_q;

endmodule // scp_spi_port

// File: pkg/scp_map.vh
// Constants for the serial control port: config register layout,
// instruction word fields, byte-count codes and the fixed bus address.
// Assumes it is included by bare name from the design files.
`ifndef SCP_MAP_VH
`define SCP_MAP_VH

// Config register kept inside the port logic
`define SCP_CFG_ADDR      13'h0000
`define SCP_CFG_RESET     8'h00
`define SCP_CFG_LSB_BIT   6
`define SCP_CFG_UNI_BIT   7

// Instruction word layout
`define SCP_INSTR_BITS    16
`define SCP_INSTR_RW_BIT  15
`define SCP_INSTR_CNT_HI  14
`define SCP_INSTR_CNT_LO  13
`define SCP_INSTR_ADR_HI  12

// Byte-count field codes
`define SCP_CNT_ONE       2'h0
`define SCP_CNT_TWO       2'h1
`define SCP_CNT_THREE     2'h2
`define SCP_CNT_STREAM    2'h3

// Upper five bits of the 7-bit bus address
`define SCP_BUS_ADDR_HI   5'h1B

`endif

// File: verilog/scp_sync.v
// Two-flop synchroniser for a group of asynchronous inputs.
// Assumes every bit is a level from outside the ref clock domain.
`timescale 1ns/1ps

module scp_sync #(
  parameter       WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             ref_clk_in,  // Sampling clock
  input  wire             rst_n_in,    // Synchronous reset, active low
  input  wire [WIDTH-1:0] async_in,    // Asynchronous levels
  output wire [WIDTH-1:0] sync_out     // Synchronised levels
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;

  ////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      stage1_q <= RST_VAL;
      stage2_q <= RST_VAL;
    end
    else
    begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;

endmodule // scp_sync

// File: bench/scp_port_monitor.sv
// Concurrent checks on the serial control port's pins and strobes.
// Assumes a synchronous active-low reset and the 40 MHz ref clock.
`timescale 1ns/1ps
module scp_port_monitor #(
  parameter ADDR_W = 13, // Address width
  parameter DATA_W = 8   // Data width
) (
  input wire              ref_clk_in,                // Ref clock
  input wire              rst_n_in,                  // Reset
  input wire              interface_select_pin_in,   // Port select
  input wire              addr_strap_upper_in,       // Strap bit 1
  input wire              addr_strap_lower_in,       // Strap bit 0
  input wire              cs_n_in,                   // Chip select
  input wire              readback_active_in,        // Read source
  input wire              sdio_oe_out,               // SDIO enable
  input wire              serial_data_output_oe_out, // SERIAL_DATA_OUTPUT enable
  input wire [ADDR_W-1:0] reg_addr_out,              // Map address
  input wire              reg_wr_out,                // Write strobe
  input wire              reg_rd_out,                // Read strobe
  input wire              reg_rd_active_out,         // Source used
  input wire              cfg_unidir_out,            // Four-wire mode
  input wire              spi_mode_out,              // SPI selected
  input wire [6:0]        i2c_addr_out,              // Bus address
  input wire              busy_out                   // Frame active
);
  reg [2:0] age_q;
  // Cycles since reset release, saturating
  always @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      age_q <= 3'h0;
    else if (age_q != 3'h7)
      age_q <= age_q + 3'h1;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Deselected for four cycles, covering the pin synchroniser and the enable flop
  sequence cs_idle;
    cs_n_in[*4];
  endsequence
  // Strobe followed by eight quiet cycles
  sequence wr_quiet;
    !reg_wr_out[*8];
  endsequence
  oe_idle_a: assert property (cs_idle |-> !sdio_oe_out && !serial_data_output_oe_out)
    else $error("data pin driven while deselected");
  wr_gap_a: assert property (reg_wr_out |=> wr_quiet)
    else $error("write strobe too long");
  rd_gap_a: assert property (reg_rd_out |=> !reg_rd_out[*8])
    else $error("read strobe too long");
  cfg_nowr_a: assert property (reg_wr_out |-> reg_addr_out != {ADDR_W{1'b0}})
    else $error("config write reached the map");
  uni_sdio_a: assert property (cfg_unidir_out |-> !sdio_oe_out)
    else $error("SDIO driven in four-wire mode");
  sel_spi_a: assert property (age_q == 3'h7 && $fell(interface_select_pin_in) |-> ##[1:4] spi_mode_out)
    else $error("SPI not selected");
  sel_i2c_a: assert property (age_q == 3'h7 && $rose(interface_select_pin_in) |-> ##[1:4] !spi_mode_out)
    else $error("SPI not released");
  bus_addr_a: assert property ($stable({addr_strap_upper_in, addr_strap_lower_in})[*4] ##0
      age_q == 3'h7 |-> i2c_addr_out == {5'h1B, addr_strap_upper_in, addr_strap_lower_in})
    else $error("bus address wrong");
  frame_go_a: assert property ($fell(cs_n_in) && !busy_out && spi_mode_out |-> ##[1:6] busy_out)
    else $error("frame did not start");
  rd_drive_a: assert property (reg_rd_out |-> ##[0:12] (sdio_oe_out || serial_data_output_oe_out))
    else $error("read data not driven");
  rd_src_a: assert property ($stable(readback_active_in)[*4] ##0 reg_rd_out
      |=> ##[0:2] reg_rd_active_out == readback_active_in)
    else $error("read source wrong");
endmodule // scp_port_monitor

bind scp_spi_port scp_port_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) scp_port_monitor_i (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .interface_select_pin_in(interface_select_pin_in),
  .addr_strap_upper_in(addr_strap_upper_in), .addr_strap_lower_in(addr_strap_lower_in),
  .cs_n_in(cs_n_in), .readback_active_in(readback_active_in), .sdio_oe_out(sdio_oe_out),
  .serial_data_output_oe_out(serial_data_output_oe_out), .reg_addr_out(reg_addr_out),
  .reg_wr_out(reg_wr_out), .reg_rd_out(reg_rd_out), .reg_rd_active_out(reg_rd_active_out),
  .cfg_unidir_out(cfg_unidir_out), .spi_mode_out(spi_mode_out), .i2c_addr_out(i2c_addr_out),
  .busy_out(busy_out));

// File: bench/scp_host_model.sv
// SPI master model driving the port's serial pins.
// Assumes the 40 MHz ref clock; SCLK half period is four cycles.
`timescale 1ns/1ps
module scp_host_model (
  input  wire clk_in,     // Ref clock
  input  wire sdio_d_in,  // Device SDIO value
  input  wire sdio_oe_in, // Device SDIO enable
  input  wire sdo_in,     // Device SERIAL_DATA_OUTPUT value
  input  wire uni_in,     // Read from SERIAL_DATA_OUTPUT
  output reg  sclk_out,   // Serial clock
  output reg  cs_n_out,   // Chip select
  output wire sdio_out    // Resolved SDIO level
);
  reg host_oe_q;
  reg host_d_q;
  reg last_q;
  // A released line shows the inverse of its last level
  assign sdio_out = (sdio_oe_in === 1'b1) ? sdio_d_in : (host_oe_q ? host_d_q : ~last_q);
  always @(posedge clk_in)
    last_q <= sdio_out;
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    host_oe_q = 1'b0;
    host_d_q = 1'b0;
    last_q = 1'b0;
  end
  // Select the device, then give it time
  task open_cs;
    begin
      @(posedge clk_in) cs_n_out <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
  endtask
  // Deselect, release SDIO, then wait six cycles
  task close_cs;
    begin
      cs_n_out <= 1'b1;
      host_oe_q <= 1'b0;
      repeat (6) @(posedge clk_in);
    end
  endtask
  // Data set while SCLK low, read bit taken at the rising edge
  task shift(input [15:0] tx, input integer n, input drv, output [15:0] rx);
    integer i;
    begin
      rx = 16'h0000;
      for (i = 0; i < n; i = i + 1)
      begin
        host_oe_q <= drv;
        host_d_q <= tx[n-1-i];
        repeat (4) @(posedge clk_in);
        rx = {rx[14:0], uni_in ? sdo_in : sdio_out};
        sclk_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        sclk_out <= 1'b0;
      end
    end
  endtask
endmodule // scp_host_model

// File: bench/scp_spi_port_tb.sv
// Self-checking bench for the serial control port.
// Assumes the host model and the monitor are compiled first.
`timescale 1ns/1ps
module scp_spi_port_tb;
  reg         clk_q;
  reg         rst_n_q;
  reg         sel_q;
  reg         up_q;
  reg         lo_q;
  reg         rb_q;
  reg         lsb_q;
  reg         uni_q;
  integer     fail_count;
  integer     samples_checked;
  integer     cyc_q = 0;
  reg  [20:0] wq[$];
  wire        sclk, cs_n, sdio, sdio_d, sdio_oe, serial_data_output, sdo_oe;
  wire [12:0] addr;
  wire [7:0]  wdata, rdata;
  wire        wr_stb, rd_stb, rd_act, lsb_cfg, uni_cfg, spi_mode, busy;
  wire [6:0]  i2c_addr;
  scp_spi_port scp_spi_port_i (
    .ref_clk_in(clk_q), .rst_n_in(rst_n_q), .interface_select_pin_in(sel_q),
    .addr_strap_upper_in(up_q), .addr_strap_lower_in(lo_q), .sclk_in(sclk), .cs_n_in(cs_n),
    .sdio_in(sdio), .sdio_out(sdio_d), .sdio_oe_out(sdio_oe), .serial_data_output_out(serial_data_output),
    .serial_data_output_oe_out(sdo_oe), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr_stb), .reg_rd_out(rd_stb), .reg_rdata_in(rdata), .readback_active_in(rb_q),
    .reg_rd_active_out(rd_act), .cfg_lsb_first_out(lsb_cfg), .cfg_unidir_out(uni_cfg),
    .spi_mode_out(spi_mode), .i2c_addr_out(i2c_addr), .busy_out(busy));
  scp_host_model scp_host_model_i (.clk_in(clk_q), .sdio_d_in(sdio_d), .sdio_oe_in(sdio_oe),
    .sdo_in(serial_data_output), .uni_in(uni_q), .sclk_out(sclk), .cs_n_out(cs_n), .sdio_out(sdio));
  // Register map stand-in and buffer write log
  assign rdata = addr[7:0] ^ 8'h5A;
  always @(posedge clk_q)
    if (wr_stb === 1'b1)
      wq.push_back({addr, wdata});
  // Clock and hang guard
  initial
  begin
    clk_q = 1'b0;
    forever #12.5 clk_q = ~clk_q;
  end
  always @(posedge clk_q)
  begin
    cyc_q = cyc_q + 1;
    if (cyc_q == 20000)
    begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      $display("checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  function [15:0] rev(input [15:0] v, input integer n);
    integer i;
    begin
      rev = 16'h0000;
      for (i = 0; i < n; i = i + 1)
        rev[n-1-i] = v[i];
    end
  endfunction
  // One frame: instruction, nb bytes, optional stall before each byte
  task xfer(input [15:0] ins, input integer nb, input st, input [31:0] wd, output [31:0] rd);
    reg [15:0] r;
    integer k;
    begin
      rd = 32'h0;
      scp_host_model_i.open_cs;
      scp_host_model_i.shift(lsb_q ? rev(ins, 16) : ins, 16, 1'b1, r);
      for (k = 0; k < nb; k = k + 1)
      begin
        if (st)
        begin
          scp_host_model_i.close_cs;
          scp_host_model_i.open_cs;
        end
        scp_host_model_i.shift(lsb_q ? rev(wd[8*k+:8], 8) : wd[8*k+:8], 8, !ins[15], r);
        rd[8*k+:8] = lsb_q ? rev(r, 8) : r[7:0];
      end
      scp_host_model_i.close_cs;
    end
  endtask
  task wr_run(input [1:0] c, input [12:0] a, input integer nb, input st, input [31:0] wd);
    reg [31:0] r;
    integer k;
    begin
      xfer({1'b0, c, a}, nb, st, wd, r);
      chk(wq.size(), nb);
      for (k = 0; k < nb; k = k + 1)
        chk(wq.pop_front(), {lsb_q ? a + k[12:0] : a - k[12:0], wd[8*k+:8]});
    end
  endtask
  task rd_run(input [1:0] c, input [12:0] a, input integer nb);
    reg [31:0] r;
    reg [12:0] e;
    integer k;
    begin
      rb_q <= c[0];
      xfer({1'b1, c, a}, nb, 1'b0, 32'h0, r);
      for (k = 0; k < nb; k = k + 1)
      begin
        e = lsb_q ? a + k[12:0] : a - k[12:0];
        chk(r[8*k+:8], e[7:0] ^ 8'h5A);
      end
      chk(rd_act, c[0]);
    end
  endtask
  task t_pins;
    integer i;
    begin
      chk({lsb_cfg, uni_cfg, sdio_oe, sdo_oe, spi_mode}, 5'h01);
      for (i = 0; i < 4; i = i + 1)
      begin
        up_q <= i[1];
        lo_q <= i[0];
        repeat (6) @(posedge clk_q);
        chk(i2c_addr, {5'h1B, i[1:0]});
      end
      sel_q <= 1'b1;
      repeat (6) @(posedge clk_q);
      chk(spi_mode, 1'b0);
      sel_q <= 1'b0;
      repeat (6) @(posedge clk_q);
      chk(spi_mode, 1'b1);
      $display("pins done");
    end
  endtask
  task t_writes;
    integer c;
    begin
      for (c = 0; c < 3; c = c + 1)
        wr_run(c[1:0], 13'h0010 + {c[9:0], 3'h0}, c + 1, c[1] | c[0], 32'h3C2D1E0F);
      wr_run(2'h3, 13'h0020, 4, 1'b0, 32'h88776655);
      $display("writes done");
    end
  endtask
  task t_reads;
    integer c;
    begin
      for (c = 0; c < 4; c = c + 1)
        rd_run(c[1:0], 13'h0030, c + 1);
      $display("reads done");
    end
  endtask
  task t_abort;
    reg [15:0] r;
    begin
      scp_host_model_i.open_cs;
      scp_host_model_i.shift(16'h0007, 16, 1'b1, r);
      scp_host_model_i.shift(16'h0005, 3, 1'b1, r);
      scp_host_model_i.close_cs;
      chk(wq.size(), 0);
      chk(busy, 1'b0);
      wr_run(2'h0, 13'h0007, 1, 1'b0, 32'hA5);
      $display("abort done");
    end
  endtask
  task t_cfg;
    reg [31:0] r;
    begin
      xfer(16'h0000, 1, 1'b0, 32'hC0, r);
      chk(wq.size(), 0);
      chk({lsb_cfg, uni_cfg}, 2'h3);
      lsb_q = 1'b1;
      uni_q <= 1'b1;
      rd_run(2'h1, 13'h0040, 2);
      xfer(16'h8000, 1, 1'b0, 32'h0, r);
      chk(r[7:0], 8'hC0);
      $display("config done");
    end
  endtask
  // Reset between frames must restore the default port mode
  task t_reset;
    begin
      rst_n_q <= 1'b0;
      repeat (12) @(posedge clk_q);
      rst_n_q <= 1'b1;
      repeat (2) @(posedge clk_q);
      chk({lsb_cfg, uni_cfg, sdio_oe, sdo_oe, busy, spi_mode}, 6'h01);
      repeat (6) @(posedge clk_q);
      $display("reset done");
    end
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    rst_n_q = 1'b0;
    sel_q = 1'b0;
    up_q = 1'b0;
    lo_q = 1'b0;
    rb_q = 1'b0;
    lsb_q = 1'b0;
    uni_q = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_q);
    rst_n_q <= 1'b1;
    repeat (8) @(posedge clk_q);
    t_pins;
    t_writes;
    t_reads;
    t_abort;
    t_cfg;
    t_reset;
    give_verdict;
  end
endmodule // scp_spi_port_tb
